// ### hw/sct_pkg.sv
// constants and types for the sdram command timing block
// Notes on behaviour
// - column commands accepted every cycle
// - burst stop on read floats outputs after latency
// - burst stop on write ignores data immediately
// - precharge on read floats outputs after latency
// - precharge on write blocks data immediately
// - read auto-close precharges before last output, except in one-word bursts
// - read mask blanks output two cycles later
// - write mask blocks input same cycle
// - read data six or five cycles after activate
package sct_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int MASK_TO_OUTPUT_LATENCY = 2;
   localparam int MASK_TO_INPUT_LATENCY = 0;
   localparam int WRITE_STOP_TO_IGNORE = 0;
   localparam int CAS_LSB = 4;
   localparam int CAS_MSB = 6;
   localparam logic [2:0] CAS_RESET = 3'h3;
   localparam int BURST_LSB = 0;
   localparam int BURST_MSB = 2;
   localparam logic [2:0] BURST_RESET = 3'h3;
   localparam int PIPE_DEPTH = 4;
   typedef enum logic [2:0] {
      SCT_CMD_NOP = 3'h0,
      SCT_CMD_ACT = 3'h1,
      SCT_CMD_RD = 3'h2,
      SCT_CMD_WR = 3'h3,
      SCT_CMD_PRE = 3'h4,
      SCT_CMD_STOP = 3'h5,
      SCT_CMD_MODE = 3'h6,
      SCT_CMD_REF = 3'h7
   } sct_cmd_e;
   typedef enum logic [1:0] {
      SCT_IDLE = 2'h0,
      SCT_READ = 2'h1,
      SCT_WRITE = 2'h2
   } sct_state_e;
endpackage

// ### hw/sct_skid.sv
// two-entry buffer with valid and ready on both sides
module sct_skid #(
   parameter int WIDTH = 16
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem_q [2];
   logic [WIDTH-1:0] mem_d [2];
   logic wp_q, wp_d, rp_q, rp_d;
   logic [1:0] cnt_q, cnt_d;
   logic push, pop;

   // next pointers and contents; full stalls the source
   always_comb begin
      push = in_valid && (cnt_q != 2'h2);
      pop = out_valid && out_ready;
      mem_d = mem_q;
      wp_d = wp_q;
      rp_d = rp_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wp_q] = in_data;
         wp_d = ~wp_q;
      end
      if (pop) begin
         rp_d = ~rp_q;
      end
      cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mem_q[0] <= '0;
         mem_q[1] <= '0;
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         mem_q <= mem_d;
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
      end
   end

   assign in_ready = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data = mem_q[rp_q];
endmodule

// ### hw/sct_core.sv
// sdram device-side data path timing: latency, mask, stop and close
module sct_core
   import sct_pkg::*;
#(
   parameter int DATA_W = 16,
   parameter int BANKS = 4
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [2:0] cmd,
   input wire logic [1:0] bank,
   input wire logic auto_close,
   input wire logic [12:0] mode_word,
   input wire logic data_mask,
   input wire logic [DATA_W-1:0] wr_data,
   output logic wr_valid,
   input wire logic wr_ready,
   output logic [DATA_W-1:0] wr_word,
   input wire logic [DATA_W-1:0] array_rd_data,
   output logic [DATA_W-1:0] dq_out,
   output logic dq_oe,
   output logic [BANKS-1:0] bank_open,
   output logic close_start,
   output logic [2:0] cas_latency
);
   ////////////////////////////////////////////////////////////////////////
   // mode register holding latency and burst length
   logic [2:0] cas_q, cas_d, blen_q, blen_d;
   logic [BANKS-1:0] open_q, open_d;
   logic [1:0] close_bank_q, close_bank_d;
   logic close_fire;

   // mode load only honoured with every bank idle
   always_comb begin
      cas_d = cas_q;
      blen_d = blen_q;
      if (cmd == SCT_CMD_MODE && open_q == '0) begin
         cas_d = mode_word[CAS_MSB:CAS_LSB];
         blen_d = mode_word[BURST_MSB:BURST_LSB];
      end
   end

   // row state per bank, precharge closes (all banks not modelled)
   always_comb begin
      open_d = open_q;
      if (cmd == SCT_CMD_ACT) begin
         open_d[bank] = 1'b1;
      end
      if (cmd == SCT_CMD_PRE) begin
         open_d[bank] = 1'b0;
      end
      if (close_fire) begin
         open_d[close_bank_q] = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // burst tracking
   sct_state_e st_q, st_d;
   logic [7:0] left_q, left_d;
   logic [7:0] blen_words;
   logic auto_q, auto_d;

   // burst length in words: 1,2,4,8, else full page
   always_comb begin
      unique case (blen_q)
         3'h0: blen_words = 8'h01;
         3'h1: blen_words = 8'h02;
         3'h2: blen_words = 8'h04;
         3'h3: blen_words = 8'h08;
         default: blen_words = 8'hff;
      endcase
   end

   // new column command restarts the burst the next cycle
   always_comb begin
      st_d = st_q;
      left_d = left_q;
      auto_d = auto_q;
      close_bank_d = close_bank_q;
      if (st_q != SCT_IDLE && left_q != 8'h00) begin
         left_d = left_q - 8'h01;
      end
      if (st_q != SCT_IDLE && left_q == 8'h01) begin
         st_d = SCT_IDLE;
      end
      if (cmd == SCT_CMD_RD || cmd == SCT_CMD_WR) begin
         st_d = (cmd == SCT_CMD_RD) ? SCT_READ : SCT_WRITE;
         left_d = blen_words;
         auto_d = auto_close;
         close_bank_d = bank;
      end else if (cmd == SCT_CMD_STOP || cmd == SCT_CMD_PRE) begin
         st_d = SCT_IDLE;
         left_d = 8'h00;
         auto_d = 1'b0;
      end
   end

   // last word leaves latency-1 edges after burst end, so firing in the
   // last word's cycle lands latency-1 ahead at both latencies;
   // limitation: a one-word burst never closes its row by itself
   assign close_fire = auto_q && st_q == SCT_READ &&
      left_q == 8'h02;

   ////////////////////////////////////////////////////////////////////////
   // read pipeline: words and drive delayed by cas latency, mask by two cycles
   logic [DATA_W-1:0] rp_q [PIPE_DEPTH];
   logic [DATA_W-1:0] rp_d [PIPE_DEPTH];
   logic [PIPE_DEPTH-1:0] en_q, en_d;
   logic msk_q, msk_d;
   logic rd_now;
   logic [DATA_W-1:0] dq_d;
   logic oe_d;
   logic [1:0] tap;

   // burst word taken in the command cycle keeps the latency exact
   assign rd_now = (st_d == SCT_READ);
   assign tap = cas_q[1:0] - 2'h2;

   always_comb begin
      rp_d[0] = array_rd_data;
      en_d[0] = rd_now;
      for (int i = 1; i < PIPE_DEPTH; i++) begin
         rp_d[i] = rp_q[i-1];
         en_d[i] = en_q[i-1];
      end
      // stop or precharge kills the word entering the pipe; words in flight still drive, float after latency
      if (cmd == SCT_CMD_STOP || cmd == SCT_CMD_PRE) begin
         en_d[0] = 1'b0;
      end
      msk_d = data_mask;
      oe_d = en_q[tap];
      dq_d = msk_q ? '0 : rp_q[tap];
      if (msk_q) begin
         oe_d = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // write path: mask or stop blocks the word in the same cycle
   logic wr_take, buf_ready;
   assign wr_take = st_q == SCT_WRITE && !data_mask
      && cmd != SCT_CMD_STOP && cmd != SCT_CMD_PRE;

   // no upstream stall, buffer ready is left unused; word lost if array is slow
   sct_skid #(.WIDTH(DATA_W)) u_buf (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .in_valid(wr_take),
      .in_ready(buf_ready),
      .in_data(wr_data),
      .out_valid(wr_valid),
      .out_ready(wr_ready),
      .out_data(wr_word)
   );

   ////////////////////////////////////////////////////////////////////////
   // register every state group
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cas_q <= CAS_RESET;
         blen_q <= BURST_RESET;
         open_q <= '0;
         st_q <= SCT_IDLE;
         left_q <= 8'h00;
         auto_q <= 1'b0;
         close_bank_q <= 2'h0;
         en_q <= '0;
         msk_q <= 1'b0;
         for (int i = 0; i < PIPE_DEPTH; i++) begin
            rp_q[i] <= '0;
         end
         dq_out <= '0;
         dq_oe <= 1'b0;
         bank_open <= '0;
         close_start <= 1'b0;
         cas_latency <= CAS_RESET;
      end else begin
         cas_q <= cas_d;
         blen_q <= blen_d;
         open_q <= open_d;
         st_q <= st_d;
         left_q <= left_d;
         auto_q <= auto_d;
         close_bank_q <= close_bank_d;
         en_q <= en_d;
         msk_q <= msk_d;
         rp_q <= rp_d;
         dq_out <= dq_d;
         dq_oe <= oe_d;
         bank_open <= open_d;
         close_start <= close_fire;
         cas_latency <= cas_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   mask_blank_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      data_mask |-> ##2 !dq_oe)
      else $error("masked read word was driven");
   write_mask_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      data_mask |-> !wr_take)
      else $error("masked write word was taken");
   stop_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (cmd == SCT_CMD_STOP) |-> !wr_take ##1 st_q == SCT_IDLE)
      else $error("write word taken at burst stop");
   pre_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (cmd == SCT_CMD_PRE) |-> !wr_take)
      else $error("write word taken at precharge");
   stop_float_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (cmd == SCT_CMD_STOP && cas_q == 3'h3 && data_mask == 1'b0)
      ##1 (cmd == SCT_CMD_NOP) [*3] |-> !dq_oe)
      else $error("outputs driven after stop latency");
   pre_float_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (cmd == SCT_CMD_PRE && cas_q == 3'h2)
      ##1 (cmd == SCT_CMD_NOP) [*2] |-> !dq_oe)
      else $error("outputs driven after precharge latency");
   col_accept_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (cmd == SCT_CMD_RD) |=> st_q == SCT_READ)
      else $error("column command not accepted next cycle");
   mode_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (cmd == SCT_CMD_MODE && open_q != '0) |=> $stable(cas_q))
      else $error("mode loaded with a bank open");
   read_lat_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (cmd == SCT_CMD_RD && cas_q == 3'h3 && !auto_close)
      ##1 (cmd == SCT_CMD_NOP && !data_mask) [*4] |-> dq_oe)
      else $error("read data not driven after latency");
   auto_close_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      close_start |-> !bank_open[close_bank_q])
      else $error("auto close did not close bank");
   buf_full_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !buf_ready |-> wr_valid)
      else $error("write buffer full but shows no word");
endmodule

// ### test/sct_ctrl_model.sv
// controller-side partner driving commands, mask and data words
module sct_ctrl_model
   import sct_pkg::*;
(
   input wire logic clk_sys,
   output logic [2:0] cmd,
   output logic [1:0] bank,
   output logic auto_close,
   output logic [12:0] mode_word,
   output logic data_mask,
   output logic [15:0] wr_data,
   output logic [15:0] array_rd_data
);
   // 100 us of quiet clocks at the 10 ns bench period
   localparam int INIT_WAIT_CYC = 10000;
   int cyc_q = 0;
   ////////////////////////////////////////
   // words change every edge, so each word names its edge
   assign wr_data = 16'(cyc_q);
   assign array_rd_data = ~16'(cyc_q);
   always @(posedge clk_sys) cyc_q <= cyc_q + 1;
   initial begin
      cmd = SCT_CMD_NOP;
      bank = 2'h0;
      auto_close = 1'b0;
      mode_word = 13'h0;
      data_mask = 1'b0;
   end
   ////////////////////////////////////////
   // gap is the edge count until the next command is sampled
   task automatic issue(input logic [2:0] c, input logic [1:0] b,
      input logic ac, input logic [12:0] mw, input int gap,
      output int at);
      cmd <= c;
      bank <= b;
      auto_close <= ac;
      mode_word <= mw;
      @(posedge clk_sys);
      at = cyc_q;
      // gaps chosen from ns limits at 10 ns, rounded up
      if (gap > 1) begin
         cmd <= SCT_CMD_NOP;
         repeat (gap - 1) @(posedge clk_sys);
      end
   endtask
   // power-up: quiet wait, close, two refreshes, then mode set;
   // clock enable stays high, no self-refresh or power down
   task automatic init();
      int t;
      repeat (INIT_WAIT_CYC) @(posedge clk_sys);
      issue(SCT_CMD_PRE, 2'h0, 1'b0, 13'h0, 2, t);
      issue(SCT_CMD_REF, 2'h0, 1'b0, 13'h0, 6, t);
      issue(SCT_CMD_REF, 2'h0, 1'b0, 13'h0, 6, t);
      issue(SCT_CMD_MODE, 2'h0, 1'b0, 13'h033, 2, t);
   endtask
   // one-edge mask pulse
   task automatic mask_pulse(output int at);
      data_mask <= 1'b1;
      @(posedge clk_sys);
      at = cyc_q;
      data_mask <= 1'b0;
   endtask
endmodule

// ### test/tb_top.sv
// self-checking bench for the sdram data path timing block
module tb_top
   import sct_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic wr_ready = 1'b1;
   logic [2:0] cmd, cas_latency;
   logic [1:0] bank;
   logic auto_close, data_mask, wr_valid, dq_oe, close_start;
   logic [12:0] mode_word;
   logic [15:0] wr_data, array_rd_data, wr_word, dq_out;
   logic [3:0] bank_open;
   int bad_count = 0;
   int cmp_count = 0;
   int a, r, s, m, l;
   logic oe_h [16384];
   logic cs_h [16384];
   logic [15:0] dq_h [16384];
   logic [15:0] wq [$];
   always #5 clk_sys = ~clk_sys;
   sct_core u_sct_core (.clk_sys(clk_sys), .rst_b(rst_b), .cmd(cmd),
      .bank(bank), .auto_close(auto_close), .mode_word(mode_word),
      .data_mask(data_mask), .wr_data(wr_data), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_word(wr_word),
      .array_rd_data(array_rd_data), .dq_out(dq_out), .dq_oe(dq_oe),
      .bank_open(bank_open), .close_start(close_start),
      .cas_latency(cas_latency));
   sct_ctrl_model u_sct_ctrl_model (.clk_sys(clk_sys), .cmd(cmd),
      .bank(bank), .auto_close(auto_close), .mode_word(mode_word),
      .data_mask(data_mask), .wr_data(wr_data),
      .array_rd_data(array_rd_data));
   ////////////////////////////////////////
   // history per edge number; sampled values, so no race with the design
   always @(posedge clk_sys) begin
      oe_h[u_sct_ctrl_model.cyc_q[13:0]] = dq_oe;
      cs_h[u_sct_ctrl_model.cyc_q[13:0]] = close_start;
      dq_h[u_sct_ctrl_model.cyc_q[13:0]] = dq_out;
      if (wr_valid === 1'b1 && wr_ready) wq.push_back(wr_word);
   end
   task automatic chk(input string what, input logic [15:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [15:0] n_h(input int f, t, input bit c);
      n_h = 16'h0;
      for (int i = f; i <= t; i++)
         n_h += 16'(c ? cs_h[i] : oe_h[i]);
   endfunction
   task automatic go(input logic [2:0] c, input logic [1:0] b,
      input logic ac, input int gap, output int at);
      u_sct_ctrl_model.issue(c, b, ac, 13'h0, gap, at);
   endtask
   ////////////////////////////////////////
   // read at latency 3 with one masked word
   task automatic t_read();
      go(SCT_CMD_ACT, 2'h1, 1'b0, 3, a);
      go(SCT_CMD_RD, 2'h1, 1'b0, 2, r);
      u_sct_ctrl_model.mask_pulse(m);
      repeat (16) @(posedge clk_sys);
      chk("first", {oe_h[a+5], oe_h[a+6]}, 16'h1);
      chk("mask", {oe_h[m+1], oe_h[m+2], oe_h[m+3]}, 16'h5);
      chk("words", n_h(a, a + 20, 0), 16'h7);
      chk("dqm", dq_h[m+2], 16'h0);
      chk("dq", dq_h[m+3], ~16'(m));
      chk("open", 16'(bank_open), 16'h2);
      go(SCT_CMD_PRE, 2'h1, 1'b0, 3, s);
      $display("test read done");
   endtask
   // auto-close read: internal close two edges before last word
   task automatic t_close();
      go(SCT_CMD_ACT, 2'h2, 1'b0, 3, a);
      go(SCT_CMD_RD, 2'h2, 1'b1, 20, r);
      for (int i = a; i < a + 24; i++) begin
         if (oe_h[i] === 1'b1) l = i;
         if (cs_h[i] === 1'b1) s = i;
      end
      chk("pulses", n_h(a, a + 21, 1), 16'h1);
      chk("close", 16'(l - s), 16'h2);
      chk("shut", 16'(bank_open), 16'h0);
      $display("test close done");
   endtask
   // stop or precharge cuts a read burst
   task automatic t_rcut(input logic [2:0] c);
      go(SCT_CMD_ACT, 2'h3, 1'b0, 3, a);
      go(SCT_CMD_RD, 2'h3, 1'b0, 3, r);
      go(c, 2'h3, 1'b0, 2, s);
      go(SCT_CMD_PRE, 2'h3, 1'b0, 16, m);
      chk("float", n_h(s + 3, s + 14, 0), 16'h0);
      chk("before", 16'(n_h(a, s + 2, 0) != 0), 16'h1);
      $display("test read cut done");
   endtask
   // masked word and words after a cut never leave the buffer
   task automatic t_wcut(input logic [2:0] c);
      go(SCT_CMD_ACT, 2'h0, 1'b0, 3, a);
      wq.delete();
      go(SCT_CMD_WR, 2'h0, 1'b0, 2, r);
      u_sct_ctrl_model.mask_pulse(m);
      go(c, 2'h0, 1'b0, 2, s);
      go(SCT_CMD_PRE, 2'h0, 1'b0, 12, l);
      a = 0;
      foreach (wq[i]) a += int'(wq[i] == 16'(m) || wq[i] >= 16'(s));
      chk("late", 16'(a), 16'h0);
      chk("taken", 16'(wq.size() != 0), 16'h1);
      $display("test write cut done");
   endtask
   // stalled receiver: the buffer keeps two words, then drains
   task automatic t_stall();
      wr_ready <= 1'b0;
      go(SCT_CMD_ACT, 2'h0, 1'b0, 3, a);
      wq.delete();
      go(SCT_CMD_WR, 2'h0, 1'b0, 12, r);
      chk("held", 16'(wr_valid), 16'h1);
      wr_ready <= 1'b1;
      go(SCT_CMD_PRE, 2'h0, 1'b0, 5, a);
      chk("kept", 16'(wq.size()), 16'h2);
      chk("empty", 16'(wr_valid), 16'h0);
      $display("test stall done");
   endtask
   // mode set refused with a row open, then latency 2 and burst 1
   task automatic t_mode();
      go(SCT_CMD_ACT, 2'h1, 1'b0, 3, a);
      u_sct_ctrl_model.issue(SCT_CMD_MODE, 2'h0, 1'b0, 13'h020, 3, s);
      chk("busy", 16'(cas_latency), 16'h3);
      go(SCT_CMD_PRE, 2'h1, 1'b0, 3, s);
      u_sct_ctrl_model.issue(SCT_CMD_MODE, 2'h0, 1'b0, 13'h020, 3, s);
      chk("cas", 16'(cas_latency), 16'h2);
      go(SCT_CMD_ACT, 2'h2, 1'b0, 3, a);
      go(SCT_CMD_RD, 2'h2, 1'b0, 1, r);
      go(SCT_CMD_RD, 2'h2, 1'b0, 1, r);
      go(SCT_CMD_RD, 2'h2, 1'b0, 12, r);
      chk("b2b", {oe_h[a+4], oe_h[a+5], oe_h[a+6], oe_h[a+7],
         oe_h[a+8]}, 16'he);
      $display("test mode done");
   endtask
   task automatic end_sim();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      chk("rcas", 16'(cas_latency), 16'h3);
      chk("ropen", {12'h0, bank_open}, 16'h0);
      u_sct_ctrl_model.init();
      t_read();
      t_close();
      t_rcut(SCT_CMD_STOP);
      t_rcut(SCT_CMD_PRE);
      t_wcut(SCT_CMD_STOP);
      t_wcut(SCT_CMD_PRE);
      t_stall();
      t_mode();
      end_sim();
   end
   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (12000) @(posedge clk_sys);
      bad_count++;
      end_sim();
   end
endmodule
